// ===== pkg/edp_pkg.sv
/*
 * edp_pkg: shared constants and a parity function for the ethernet datapath parity block.
 * assumes: single clock domain, 8-bit byte lanes on an axi4-stream datapath.
 */
package edp_pkg;
	localparam int DATA_BYTES    = 8;
	localparam int BYTE_BITS     = 8;
	// ****************************************
	// software register offsets (controller)
	// ****************************************
	localparam logic [3:0] REG_CTRL    = 4'h0;
	localparam logic [3:0] REG_STATUS  = 4'h4;
	localparam logic [3:0] REG_ENABLE  = 4'h8;
	localparam logic [3:0] REG_CLEAR   = 4'hc;
	localparam logic [3:0] REG_ERRCNT  = 4'h0 + 4'h0 + 4'h0;
	// ctrl fields
	localparam int CTRL_FCS_INS    = 0;
	localparam int CTRL_PAR_RESP   = 1;
	localparam int CTRL_CORRUPT    = 2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// status / interrupt fields
	localparam int ST_TX_PAR   = 0;
	localparam int ST_TX_FCS   = 1;
	localparam int ST_RX_PAR   = 2;
	localparam int ST_BITS     = 3;

	// even parity of one byte
	function automatic logic evenPar(input logic [BYTE_BITS-1:0] b);
		evenPar = ^b;
	endfunction : evenPar
endpackage : edp_pkg

// ===== pkg/edp_if.sv
/*
 * edp_if: stream link between the mac datapath end and the user logic end.
 * assumes: both ends run on the same clock; data moves on tvalid and tready.
 */
interface edp_if
	import edp_pkg::*;
	#(parameter int NB = DATA_BYTES) ();
	// ****************************************
	// transmit stream (user -> mac)
	// ****************************************
	logic [NB*8-1:0] txData;
	logic [NB-1:0]   txKeep;
	logic [NB-1:0]   txParity;
	logic            txValid;
	logic            txLast;
	logic            txReady;
	// ****************************************
	// receive stream (mac -> user)
	// ****************************************
	logic [NB*8-1:0] rxData;
	logic [NB-1:0]   rxKeep;
	logic [NB-1:0]   rxParity;
	logic            rxValid;
	logic            rxLast;
	logic            rxReady;

	modport mac (input txData, txKeep, txParity, txValid, txLast, rxReady,
		output txReady, rxData, rxKeep, rxParity, rxValid, rxLast);
	modport user (output txData, txKeep, txParity, txValid, txLast, rxReady,
		input txReady, rxData, rxKeep, rxParity, rxValid, rxLast);
endinterface : edp_if

// ===== hw/edp_mac_end.sv
/*
 * edp_mac_end: mac-side datapath parity: rx parity generation, tx parity
 * check, tx parity and fcs error flags.
 * assumes: user end on the same clock drives tx stream and accepts rx stream;
 * the fcs engine delivers the receive bytes and the user fcs check result.
 */
module edp_mac_end
	import edp_pkg::*;
	#(parameter int NB = DATA_BYTES) (
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire logic          clkEn,
	edp_if.mac                 lnk,
	input  wire logic          fcsInsEnable,
	input  wire logic          parityErrResponse,
	input  wire logic          fifoUnderflow,
	input  wire logic          userFcsBad,
	input  wire logic          userFcsBadValid,
	input  wire logic [NB*8-1:0] macRxData,
	input  wire logic [NB-1:0] macRxKeep,
	input  wire logic          macRxValid,
	input  wire logic          macRxLast,
	output logic               macRxReady,
	output logic [NB*8-1:0]    macTxData,
	output logic [NB-1:0]      macTxKeep,
	output logic               macTxValid,
	output logic               macTxLast,
	input  wire logic          macTxReady,
	output logic               txBadParity,
	output logic               txBadFcs
);
	// ****************************************
	// elaboration checks
	// ****************************************
	initial begin
		if (NB < 1 || NB > 64) $error("edp_mac_end: NB out of range");
		if (BYTE_BITS != 8) $error("edp_mac_end: lanes assume eight-bit bytes");
	end

	// ****************************************
	// declarations
	// ****************************************
	logic [NB-1:0] keptByte;
	logic [NB-1:0] cycErr;
	logic          anyErr;
	logic          suppressFlag;
	logic          txBeat;
	logic          cycBad;
	logic          pktBad_ff;
	logic          nxt_pktBad;
	logic          txBadParity_ff;
	logic          txBadFcs_ff;
	logic          nxt_txBadFcs;

	// ****************************************
	// receive path
	// ****************************************
	// rx stream passes straight to the user end
	always_comb begin
		lnk.rxData  = macRxData;
		lnk.rxKeep  = macRxKeep;
		lnk.rxValid = macRxValid;
		lnk.rxLast  = macRxLast;
		macRxReady  = lnk.rxReady;
	end

	always_comb begin
		for (int i = 0; i < NB; i++) begin
			lnk.rxParity[i] = evenPar(macRxData[i*8 +: 8]);
		end
	end

	// ****************************************
	// transmit path
	// ****************************************
	// data passes unaltered
	always_comb begin
		macTxData   = lnk.txData;
		macTxKeep   = lnk.txKeep;
		macTxValid  = lnk.txValid;
		macTxLast   = lnk.txLast;
		lnk.txReady = macTxReady;
	end

	// ****************************************
	// transmit parity check
	// ****************************************
	assign txBeat = lnk.txValid & macTxReady;

	// kept byte on a taken beat
	always_comb begin
		for (int i = 0; i < NB; i++) begin
			keptByte[i] = txBeat & lnk.txKeep[i];
		end
	end

	always_comb begin
		for (int i = 0; i < NB; i++) begin
			cycErr[i] = keptByte[i] & (evenPar(lnk.txData[i*8 +: 8]) != lnk.txParity[i]);
		end
	end

	assign anyErr = |cycErr;

	// final beat and underflow not flagged
	assign suppressFlag = lnk.txLast | fifoUnderflow;

	assign cycBad = anyErr & ~suppressFlag;

	// ****************************************
	// parity error flag
	// ****************************************
	// per-cycle pulse
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			txBadParity_ff <= 1'b0;
		end else if (clkEn) begin
			txBadParity_ff <= cycBad;
		end
	end

	// ****************************************
	// packet tracking
	// ****************************************
	// packet parity accumulation
	always_comb begin
		nxt_pktBad = pktBad_ff;
		if (txBeat && lnk.txLast) begin
			nxt_pktBad = 1'b0;
		end else if (cycBad) begin
			nxt_pktBad = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pktBad_ff <= 1'b0;
		end else if (clkEn) begin
			pktBad_ff <= nxt_pktBad;
		end
	end

	// ****************************************
	// fcs error flag
	// ****************************************
	// response by configuration
	always_comb begin
		nxt_txBadFcs = 1'b0;
		case ({fcsInsEnable, parityErrResponse})
			2'b00, 2'b01: begin
				nxt_txBadFcs = userFcsBadValid & userFcsBad;
			end
			2'b10: begin
				nxt_txBadFcs = 1'b0;
			end
			2'b11: begin
				nxt_txBadFcs = txBeat & lnk.txLast & pktBad_ff;
			end
			default: begin
				nxt_txBadFcs = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			txBadFcs_ff <= 1'b0;
		end else if (clkEn) begin
			txBadFcs_ff <= nxt_txBadFcs;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign txBadParity = txBadParity_ff;
	assign txBadFcs    = txBadFcs_ff;
endmodule : edp_mac_end

// ===== hw/edp_user_end.sv
/*
 * edp_user_end: user-side logic: adds even parity to transmit bytes (odd while ctrl bit CTRL_CORRUPT is set), checks
 * parity of received valid bytes, status and interrupt registers.
 * assumes: mac end on the same clock; software uses a plain strobe port.
 */
module edp_user_end
	import edp_pkg::*;
	#(parameter int NB = DATA_BYTES) (
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire logic          clkEn,
	edp_if.user                lnk,
	input  wire logic [NB*8-1:0] srcData,
	input  wire logic [NB-1:0] srcKeep,
	input  wire logic          srcValid,
	input  wire logic          srcLast,
	output logic               srcReady,
	output logic [NB*8-1:0]    dstData,
	output logic [NB-1:0]      dstKeep,
	output logic               dstValid,
	output logic               dstLast,
	input  wire logic          dstReady,
	input  wire logic          txBadParity,
	input  wire logic          txBadFcs,
	input  wire logic [3:0]    regAddr,
	input  wire logic [31:0]   regWdata,
	input  wire logic          regWr,
	input  wire logic          regRd,
	output logic [31:0]        regRdata,
	output logic               irq
);
	initial begin
		if (NB < 1 || NB > 64) $error("edp_user_end: NB out of range");
	end

	logic [31:0]        ctrl_ff;
	logic [ST_BITS-1:0] status_ff;
	logic [ST_BITS-1:0] enable_ff;
	logic [31:0]        regRdata_ff;
	logic               irq_ff;
	logic [ST_BITS-1:0] evt;
	logic               rxErr;

	// ****************************************
	// transmit: parity generation
	// ****************************************
	always_comb begin
		lnk.txData  = srcData;
		lnk.txKeep  = srcKeep;
		lnk.txValid = srcValid;
		lnk.txLast  = srcLast;
		srcReady    = lnk.txReady;
		for (int i = 0; i < NB; i++) begin
			lnk.txParity[i] = evenPar(srcData[i*8 +: 8]) ^ ctrl_ff[CTRL_CORRUPT];
		end
	end

	// ****************************************
	// receive: parity check
	// ****************************************
	always_comb begin
		dstData     = lnk.rxData;
		dstKeep     = lnk.rxKeep;
		dstValid    = lnk.rxValid;
		dstLast     = lnk.rxLast;
		lnk.rxReady = dstReady;
		rxErr       = 1'b0;
		for (int i = 0; i < NB; i++) begin
			if (lnk.rxValid && dstReady && lnk.rxKeep[i]
				&& evenPar(lnk.rxData[i*8 +: 8]) != lnk.rxParity[i]) begin
				rxErr = 1'b1;
			end
		end
	end

	assign evt = {rxErr, txBadFcs, txBadParity};

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff   <= CTRL_RESET;
			enable_ff <= '0;
		end else if (clkEn && regWr) begin
			if (regAddr == REG_CTRL) ctrl_ff <= regWdata;
			if (regAddr == REG_ENABLE) enable_ff <= regWdata[ST_BITS-1:0];
		end
	end

	// sticky status, set wins over clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status_ff <= '0;
		end else if (clkEn) begin
			if (regWr && regAddr == REG_CLEAR) begin
				status_ff <= (status_ff & ~regWdata[ST_BITS-1:0]) | evt;
			end else begin
				status_ff <= status_ff | evt;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			regRdata_ff <= 32'h0000_0000;
		end else if (clkEn) begin
			regRdata_ff <= 32'h0000_0000;
			if (regRd) begin
				case (regAddr)
					REG_CTRL:   regRdata_ff <= ctrl_ff;
					REG_STATUS: regRdata_ff <= {{(32-ST_BITS){1'b0}}, status_ff};
					REG_ENABLE: regRdata_ff <= {{(32-ST_BITS){1'b0}}, enable_ff};
					default:    regRdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else if (clkEn) begin
			irq_ff <= |(status_ff & enable_ff);
		end
	end

	assign regRdata = regRdata_ff;
	assign irq      = irq_ff;
endmodule : edp_user_end

// ===== sim/edp_checker_sva.sv
/*
 * edp_checker_sva: checks on the link and the error flags.
 * assumes: one clock, async low reset, stream signals taken from the link instance, config and flags from the top.
 */
module edp_checker_sva
	import edp_pkg::*;
	#(parameter int NB = DATA_BYTES) (
	input wire logic            clock,
	input wire logic            rst_n,
	input wire logic [NB*8-1:0] txData,
	input wire logic [NB-1:0]   txKeep,
	input wire logic [NB-1:0]   txParity,
	input wire logic            txValid,
	input wire logic            txLast,
	input wire logic            txReady,
	input wire logic [NB*8-1:0] rxData,
	input wire logic [NB-1:0]   rxKeep,
	input wire logic [NB-1:0]   rxParity,
	input wire logic            rxValid,
	input wire logic            fcsInsEnable,
	input wire logic            parityErrResponse,
	input wire logic            fifoUnderflow,
	input wire logic            userFcsBad,
	input wire logic            userFcsBadValid,
	input wire logic            txBadParity,
	input wire logic            txBadFcs
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [NB-1:0] txCalc, rxCalc;
	logic          beat, flagBeat, fcsOn, errSeen_ff;
	// ****************************************
	// parity and packet tracking
	// ****************************************
	always_comb begin
		for (int i = 0; i < NB; i++) begin
			txCalc[i] = ^txData[8*i +: 8];
			rxCalc[i] = ^rxData[8*i +: 8];
		end
	end
	assign beat = txValid && txReady;
	assign flagBeat = beat && |(txKeep & (txParity ^ txCalc)) && !txLast && !fifoUnderflow;
	assign fcsOn = fcsInsEnable && parityErrResponse;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			errSeen_ff <= 1'b0;
		else if (beat)
			errSeen_ff <= flagBeat || (errSeen_ff && !txLast);
	end
	// ****************************************
	// assertions
	// ****************************************
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	property p_rxPar; rxValid |-> (rxParity & rxKeep) == (rxCalc & rxKeep); endproperty
	a_rxPar: assert property (p_rxPar) else $error("rx parity wrong");
	property p_parFlag; flagBeat |=> txBadParity; endproperty
	a_parFlag: assert property (p_parFlag) else $error("parity flag missing");
	property p_parQuiet; !flagBeat |=> !txBadParity; endproperty
	a_parQuiet: assert property (p_parQuiet) else $error("parity flag spurious");
	property p_fcsPulse; $rose(txBadFcs) |=> $fell(txBadFcs); endproperty
	a_fcsPulse: assert property (p_fcsPulse) else $error("fcs flag too long");
	property p_fcsUser; !fcsInsEnable && userFcsBadValid && userFcsBad |=> txBadFcs; endproperty
	a_fcsUser: assert property (p_fcsUser) else $error("fcs flag missing");
	property p_fcsOff; !fcsInsEnable && !(userFcsBadValid && userFcsBad) |=> !txBadFcs; endproperty
	a_fcsOff: assert property (p_fcsOff) else $error("fcs flag spurious");
	property p_fcsNoResp; fcsInsEnable && !parityErrResponse |=> !txBadFcs; endproperty
	a_fcsNoResp: assert property (p_fcsNoResp) else $error("fcs flag without response");
	property p_fcsPar; fcsOn && beat && txLast && errSeen_ff |=> txBadFcs; endproperty
	a_fcsPar: assert property (p_fcsPar) else $error("fcs flag missing on packet");
	property p_fcsLast; fcsOn && !(beat && txLast && errSeen_ff) |=> !txBadFcs; endproperty
	a_fcsLast: assert property (p_fcsLast) else $error("fcs flag off packet end");
	c_parFlag: cover property (txBadParity);
	c_fcsPar: cover property (fcsOn && txBadFcs);
	c_rx: cover property (rxValid && |rxKeep);
endmodule : edp_checker_sva

// ===== sim/ethernet_datapath_parity_tb_top.sv
/*
 * tb top: both ends joined by the link; stream, flag and register tests.
 * assumes: edp_pkg, edp_if and both end modules are compiled first.
 */
module ethernet_datapath_parity_tb_top
	import edp_pkg::*;
	();
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock, rst_n, srcValid, srcLast, dstValid, dstLast, dstReady, regWr, regRd;
	logic        txBadParity, txBadFcs, irq, fcsIns, parResp, fifoUnderflow, userFcsBad;
	logic        userFcsBadValid, macRxValid, macRxLast, macTxReady;
	logic        macRxReady, macTxValid, macTxLast, srcReady;
	logic [63:0] srcData, dstData, macRxData, macTxData;
	logic [7:0]  srcKeep, dstKeep, macRxKeep, macTxKeep;
	logic [3:0]  regAddr;
	logic [31:0] regWdata, regRdata;
	int          errors, compares;
	logic [63:0] pats [4] = '{64'h0, '1, 64'h0123_4567_89ab_cdef, 64'h8001_fe7f_00ff_113c};
	edp_if edp_if_i ();
	edp_mac_end edp_mac_end_i (.clock(clock), .rst_n(rst_n), .clkEn(1'b1), .lnk(edp_if_i),
		.fcsInsEnable(fcsIns), .parityErrResponse(parResp), .fifoUnderflow(fifoUnderflow),
		.userFcsBad(userFcsBad), .userFcsBadValid(userFcsBadValid), .macRxData(macRxData),
		.macRxKeep(macRxKeep), .macRxValid(macRxValid), .macRxLast(macRxLast),
		.macRxReady(macRxReady), .macTxData(macTxData), .macTxKeep(macTxKeep),
		.macTxValid(macTxValid), .macTxLast(macTxLast),
		.macTxReady(macTxReady), .txBadParity(txBadParity), .txBadFcs(txBadFcs));
	edp_user_end edp_user_end_i (.clock(clock), .rst_n(rst_n), .clkEn(1'b1), .lnk(edp_if_i),
		.srcData(srcData), .srcKeep(srcKeep), .srcValid(srcValid), .srcLast(srcLast),
		.srcReady(srcReady), .dstData(dstData), .dstKeep(dstKeep), .dstValid(dstValid),
		.dstLast(dstLast), .dstReady(dstReady), .txBadParity(txBadParity), .txBadFcs(txBadFcs),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .irq(irq));
	edp_checker_sva edp_checker_sva_i (.clock(clock), .rst_n(rst_n),
		.txData(edp_if_i.txData), .txKeep(edp_if_i.txKeep), .txParity(edp_if_i.txParity),
		.txValid(edp_if_i.txValid), .txLast(edp_if_i.txLast), .txReady(edp_if_i.txReady),
		.rxData(edp_if_i.rxData), .rxKeep(edp_if_i.rxKeep), .rxParity(edp_if_i.rxParity),
		.rxValid(edp_if_i.rxValid), .fcsInsEnable(fcsIns), .parityErrResponse(parResp),
		.fifoUnderflow(fifoUnderflow), .userFcsBad(userFcsBad),
		.userFcsBadValid(userFcsBadValid), .txBadParity(txBadParity), .txBadFcs(txBadFcs));
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] expPar(input logic [63:0] d);
		for (int i = 0; i < 8; i++)
			expPar[i] = ^d[8*i +: 8];
	endfunction : expPar
	task automatic chkV(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkV
	task automatic chkF(input logic got, input logic exp);
		chkV({63'h0, got}, {63'h0, exp});
	endtask : chkF
	task automatic wrap_up;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clock);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		@(negedge clock);
		chkV(64'(regRdata), 64'(e));
	endtask : rd
	task automatic beat(input logic [63:0] d, input logic [7:0] k, input logic l, input logic e);
		@(posedge clock);
		srcData <= d;
		srcKeep <= k;
		srcLast <= l;
		srcValid <= 1'b1;
		@(negedge clock);
		chkF(txBadParity, e);
	endtask : beat
	task automatic idle(input logic eP, input logic eF);
		@(posedge clock);
		srcValid <= 1'b0;
		macRxValid <= 1'b0;
		@(negedge clock);
		chkF(txBadParity, eP);
		chkF(txBadFcs, eF);
	endtask : idle
	// ****************************************
	// clock, watchdog, tests
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		wrap_up();
	end
	initial begin
		{rst_n, srcValid, srcLast, regWr, regRd, fcsIns, parResp, fifoUnderflow} = '0;
		{userFcsBad, userFcsBadValid, macRxValid, macRxLast, srcData, macRxData} = '0;
		{srcKeep, macRxKeep, regAddr, regWdata} = '0;
		{dstReady, macTxReady} = 2'b11;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		rd(REG_CTRL, 32'h0);
		rd(REG_STATUS, 32'h0);
		rd(REG_ENABLE, 32'h0);
		rd(4'h2, 32'h0);
		wr(REG_CTRL, 32'h7);
		rd(REG_CTRL, 32'h7);
		wr(REG_CTRL, 32'h0);
		$display("registers done");
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			{macRxData, srcData} <= {pats[i], pats[i]};
			{macRxKeep, srcKeep} <= {8'h0f << i, 8'hff};
			{macRxValid, srcValid} <= 2'b11;
			{macRxLast, srcLast} <= {2{i == 3}};
			@(negedge clock);
			chkV(64'(edp_if_i.rxParity & macRxKeep), 64'(expPar(pats[i]) & macRxKeep));
			chkV(64'(edp_if_i.txParity), 64'(expPar(pats[i])));
			chkV(dstData, pats[i]);
			chkV(macTxData, pats[i]);
			chkF(txBadParity, 1'b0);
			chkV(64'(dstKeep), 64'(macRxKeep));
			chkV(64'(macTxKeep), 64'(8'hff));
			chkF(dstValid, 1'b1);
			chkF(macTxValid, 1'b1);
			chkF(dstLast, i == 3);
			chkF(macTxLast, i == 3);
			chkF(srcReady, 1'b1);
			chkF(macRxReady, 1'b1);
		end
		idle(1'b0, 1'b0);
		$display("stream parity done");
		wr(REG_CTRL, 32'h4);
		{fcsIns, parResp} <= 2'b11;
		beat(pats[2], 8'hff, 1'b0, 1'b0);
		beat(pats[2], 8'h00, 1'b0, 1'b1);
		beat(pats[2], 8'h01, 1'b0, 1'b0);
		beat(pats[2], 8'hff, 1'b1, 1'b1);
		idle(1'b0, 1'b1);
		idle(1'b0, 1'b0);
		rd(REG_STATUS, 32'h3);
		chkF(irq, 1'b0);
		wr(REG_ENABLE, 32'h1);
		repeat (2) @(negedge clock);
		chkF(irq, 1'b1);
		wr(REG_CLEAR, 32'h7);
		rd(REG_STATUS, 32'h0);
		chkF(irq, 1'b0);
		$display("flags and interrupt done");
		for (int c = 0; c < 4; c++) begin
			@(posedge clock);
			{fcsIns, parResp} <= 2'(c);
			beat(pats[3], 8'hff, 1'b0, 1'b0);
			beat(pats[3], 8'hff, 1'b1, 1'b1);
			idle(1'b0, c == 3);
		end
		$display("configurations done");
		@(posedge clock);
		fifoUnderflow <= 1'b1;
		beat(pats[2], 8'hff, 1'b0, 1'b0);
		beat(pats[2], 8'hff, 1'b1, 1'b0);
		idle(1'b0, 1'b0);
		@(posedge clock);
		fifoUnderflow <= 1'b0;
		fcsIns <= 1'b0;
		{userFcsBad, userFcsBadValid} <= 2'b11;
		@(posedge clock);
		{userFcsBad, userFcsBadValid} <= 2'b00;
		@(negedge clock);
		chkF(txBadFcs, 1'b1);
		$display("underflow and user fcs done");
		wrap_up();
	end
endmodule : ethernet_datapath_parity_tb_top
